// ==== rtl/pll_regs_pkg.sv ====
// Package with register map, field layout, reset values and carrier types for the loop configuration registers.
`default_nettype none
package pll_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the low six bits of the index.
  localparam logic [7:0] IDX_LOOP_ENABLE = 8'h59;
  localparam logic [7:0] IDX_FILTER_RES = 8'h5a;
  localparam logic [7:0] IDX_FILTER_CAP3 = 8'h5b;
  localparam logic [7:0] IDX_FILTER_CAP1 = 8'h5c;

  // Field positions.
  localparam int UNUSED_BIT = 7;
  localparam int REFDIV_EN_BIT = 4;
  localparam int LOOP_EN_BIT = 1;
  localparam int CODE_MSB = 4;
  localparam int CODE_LSB = 0;

  // Reset values of the stored seven bits.
  localparam logic [6:0] RST_LOOP_ENABLE = 7'h41;
  localparam logic [6:0] RST_FILTER_RES = 7'h2f;
  localparam logic [6:0] RST_FILTER_CAP3 = 7'h27;
  localparam logic [6:0] RST_FILTER_CAP1 = 7'h27;

  // Value returned for an unmapped address.
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [DATA_W-1:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic loopEnable;
    logic refDividerEnable;
    logic [4:0] filterResistorCode;
    logic [4:0] filterCapThreeCode;
    logic [4:0] filterCapOneCode;
  } loop_ctrl_t;

endpackage : pll_regs_pkg
`default_nettype wire

// ==== rtl/cfg_reg7.sv ====
// Seven-bit configuration register with reset default and byte write.
`timescale 1ns/1ps
`default_nettype none
module cfg_reg7 #(
  parameter logic [6:0] RESET_VALUE = 7'h00
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic [6:0] wrData,
  output logic [6:0] value
);

  logic [6:0] value_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      value_reg <= RESET_VALUE;
    end else if (wrEn) begin
      value_reg <= wrData;
    end
  end

  assign value = value_reg;

endmodule : cfg_reg7
`default_nettype wire

// ==== rtl/bus_decode.sv ====
// Address decoder turning a word-aligned byte address into one-hot register selects.
`timescale 1ns/1ps
`default_nettype none
module bus_decode (
  input wire logic [7:0] address,
  output logic [3:0] select,
  output logic hit
);

  always_comb begin
    select = 4'h0;
    if (address[1:0] == 2'h0) begin
      case (address[7:2])
        pll_regs_pkg::IDX_LOOP_ENABLE[5:0]: select = 4'h1;
        pll_regs_pkg::IDX_FILTER_RES[5:0]: select = 4'h2;
        pll_regs_pkg::IDX_FILTER_CAP3[5:0]: select = 4'h4;
        pll_regs_pkg::IDX_FILTER_CAP1[5:0]: select = 4'h8;
        default: select = 4'h0;
      endcase
    end
  end

  assign hit = |select;

endmodule : bus_decode
`default_nettype wire

// ==== rtl/pll_enable_and_loop_filter_regs.sv ====
// Avalon-MM register bank for the clock synthesis loop enables and loop filter codes.
//
// Functional notes
// - Bit 7 of every register ignores writes and always reads zero.
// - Enable register bit 4 applies reference divider; clear bypasses it, resets clear.
// - Enable register bit 1 is the loop master enable, resets clear.
// - Third capacitor code in bits 4-0, resets to 00111, linear scale.
// - First capacitor code in bits 4-0, resets to 00111, linear scale.
// - Resistor code in bits 4-0 resets 01111, reserved bits reset 01.
`timescale 1ns/1ps
`default_nettype none
module pll_enable_and_loop_filter_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  output pll_regs_pkg::loop_ctrl_t loopCtrl
);

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    DONE = 2'b01
  } bus_state_t;

  bus_state_t state_reg;
  bus_state_t state_next;
  pll_regs_pkg::bus_req_t req;
  logic [3:0] select;
  logic hit;
  logic [3:0] wrEn;
  logic [6:0] enableVal;
  logic [6:0] resVal;
  logic [6:0] cap3Val;
  logic [6:0] cap1Val;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic [1:0] response_reg;
  logic [1:0] response_next;

  // Zero-extend a stored seven-bit value; the top byte bit stays zero.
  function automatic logic [31:0] read_word(input logic [6:0] stored);
    read_word = {25'h0000000, stored};
  endfunction : read_word

  assign req = '{read: read, write: write, address: address, byteenable: byteenable, writedata: writedata};

  bus_decode decode (
    .address(req.address),
    .select(select),
    .hit(hit)
  );

  // Every access takes one wait cycle so read data always come from a flop.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        if (req.read || req.write) begin
          state_next = DONE;
        end
      end
      DONE: state_next = IDLE;
      default: state_next = IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign waitrequest = (req.read || req.write) && (state_reg != DONE);

  // Writes commit at the edge ending the wait cycle, one cycle before the accepting edge, so the loop sees new codes as waitrequest falls.
  always_comb begin
    wrEn = 4'h0;
    if ((state_reg == IDLE) && req.write && req.byteenable[0]) begin
      wrEn = select;
    end
  end

  cfg_reg7 #(.RESET_VALUE(pll_regs_pkg::RST_LOOP_ENABLE)) enableReg (
    .clk(clk),
    .rstn(rstn),
    .wrEn(wrEn[0]),
    .wrData(req.writedata[6:0]),
    .value(enableVal)
  );

  cfg_reg7 #(.RESET_VALUE(pll_regs_pkg::RST_FILTER_RES)) resReg (
    .clk(clk),
    .rstn(rstn),
    .wrEn(wrEn[1]),
    .wrData(req.writedata[6:0]),
    .value(resVal)
  );

  cfg_reg7 #(.RESET_VALUE(pll_regs_pkg::RST_FILTER_CAP3)) cap3Reg (
    .clk(clk),
    .rstn(rstn),
    .wrEn(wrEn[2]),
    .wrData(req.writedata[6:0]),
    .value(cap3Val)
  );

  cfg_reg7 #(.RESET_VALUE(pll_regs_pkg::RST_FILTER_CAP1)) cap1Reg (
    .clk(clk),
    .rstn(rstn),
    .wrEn(wrEn[3]),
    .wrData(req.writedata[6:0]),
    .value(cap1Val)
  );

  // Factory bits are stored as written; the block trusts software to keep the defaults.
  always_comb begin
    readdata_next = readdata_reg;
    response_next = response_reg;
    if ((state_reg == IDLE) && (req.read || req.write)) begin
      response_next = hit ? 2'h0 : 2'h3;
      readdata_next = pll_regs_pkg::UNMAPPED_DATA;
      if (req.read) begin
        case (select)
          4'h1: readdata_next = read_word(enableVal);
          4'h2: readdata_next = read_word(resVal);
          4'h4: readdata_next = read_word(cap3Val);
          4'h8: readdata_next = read_word(cap1Val);
          default: readdata_next = pll_regs_pkg::UNMAPPED_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      readdata_reg <= 32'h0000_0000;
      response_reg <= 2'h0;
    end else begin
      readdata_reg <= readdata_next;
      response_reg <= response_next;
    end
  end

  assign readdata = readdata_reg;
  assign response = response_reg;

  // Outputs come straight from the stored registers, so they are glitch-free levels.
  // One assignment drives the whole struct so the output variable has a single driver.
  assign loopCtrl = '{
    loopEnable: enableVal[pll_regs_pkg::LOOP_EN_BIT],
    refDividerEnable: enableVal[pll_regs_pkg::REFDIV_EN_BIT],
    filterResistorCode: resVal[pll_regs_pkg::CODE_MSB:pll_regs_pkg::CODE_LSB],
    filterCapThreeCode: cap3Val[pll_regs_pkg::CODE_MSB:pll_regs_pkg::CODE_LSB],
    filterCapOneCode: cap1Val[pll_regs_pkg::CODE_MSB:pll_regs_pkg::CODE_LSB]
  };

endmodule : pll_enable_and_loop_filter_regs
`default_nettype wire

// ==== dv/pll_regs_asserts.sv ====
// Checker for bus answer timing and the loop control outputs.
`timescale 1ns/1ps
`default_nettype none
module pll_regs_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  input wire pll_regs_pkg::loop_ctrl_t loopCtrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic wrTake;
  assign wrTake = write && waitrequest && byteenable[0];
  a_msb_zero: assert property (readdata[31:7] == 25'h0) else $error("Upper read bits set.");
  a_refdiv_write:
    assert property (wrTake && address == 8'h64 |=> loopCtrl.refDividerEnable == $past(writedata[4]))
    else $error("Divider enable not stored.");
  a_loop_write:
    assert property (wrTake && address == 8'h64 |=> loopCtrl.loopEnable == $past(writedata[1]))
    else $error("Loop enable not stored.");
  a_cap3_write:
    assert property (wrTake && address == 8'h6c |=> loopCtrl.filterCapThreeCode == $past(writedata[4:0]))
    else $error("Cap three code not stored.");
  a_cap1_write:
    assert property (wrTake && address == 8'h70 |=> loopCtrl.filterCapOneCode == $past(writedata[4:0]))
    else $error("Cap one code not stored.");
  a_res_write:
    assert property (wrTake && address == 8'h68 |=> loopCtrl.filterResistorCode == $past(writedata[4:0]))
    else $error("Resistor code not stored.");
  // Outputs feed the analog loop directly, so any glitch without a write is a fault.
  a_ctrl_hold: assert property (!wrTake |=> $stable(loopCtrl)) else $error("Loop control moved.");
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("Late answer.");
  cover property (wrTake && address == 8'h64);
  cover property (read && !waitrequest && response == 2'h3);
  cover property (read && !waitrequest && address == 8'h70);
endmodule : pll_regs_asserts
bind pll_enable_and_loop_filter_regs pll_regs_asserts u_asserts (.clk(clk), .rstn(rstn), .address(address),
  .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .response(response), .loopCtrl(loopCtrl));
`default_nettype wire

// ==== dv/pll_enable_and_loop_filter_regs_tb_top.sv ====
// Self-checking bench for the loop configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", nm, e, a); end end
module pll_enable_and_loop_filter_regs_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  pll_regs_pkg::loop_ctrl_t loopCtrl;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [33:0] expQ[$];
  logic [6:0] mdl[4] = '{7'h41, 7'h2f, 7'h27, 7'h27};
  logic [6:0] dflt[4] = '{7'h41, 7'h2f, 7'h27, 7'h27};
  logic [6:0] mask[4] = '{7'h12, 7'h1f, 7'h1f, 7'h1f};
  always #5 clk = ~clk;
  pll_enable_and_loop_filter_regs dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .loopCtrl(loopCtrl));
  function automatic logic [16:0] ctrlExp();
    return {mdl[0][1], mdl[0][4], mdl[1][4:0], mdl[2][4:0], mdl[3][4:0]};
  endfunction : ctrlExp
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
    input logic [33:0] e);
    @(posedge clk);
    read <= rd;
    write <= !rd;
    address <= a;
    byteenable <= be;
    writedata <= d;
    expQ.push_back(e);
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask : xfer
  task automatic rdAll();
    for (int i = 0; i < 4; i++) xfer(1'b1, 8'h64 + 8'(4 * i), 4'hf, 32'h0, {2'b00, 25'h0, mdl[i]});
    `CHK("loopCtrl", ctrlExp(), loopCtrl)
  endtask : rdAll
  always @(posedge clk) begin : mon
    logic [33:0] e;
    if ((read || write) && waitrequest === 1'b0) begin
      e = expQ.pop_front();
      if (read) `CHK("readdata", e[31:0], readdata)
      `CHK("response", e[33:32], response)
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    int k;
    logic [31:0] d;
    logic [3:0] be;
    void'($urandom(36350));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdAll();
    for (int r = 0; r < 40; r++) begin
      k = $urandom % 4;
      d = $urandom;
      be = $urandom;
      d[6:0] = (d[6:0] & mask[k]) | (dflt[k] & ~mask[k]);
      xfer(1'b0, 8'h64 + 8'(4 * k), be, d, 34'h0);
      if (be[0]) mdl[k] = d[6:0];
      `CHK("loopCtrl", ctrlExp(), loopCtrl)
      if (r % 8 == 7) rdAll();
    end
    xfer(1'b0, 8'h00, 4'hf, 32'h7f, {2'b11, 32'h0});
    xfer(1'b1, 8'h00, 4'hf, 32'h0, {2'b11, 32'h0});
    rdAll();
    // Bring-up as software does it: capacitor codes first, then the master loop enable.
    mdl[2] = 7'h2c;
    xfer(1'b0, 8'h6c, 4'h1, {25'h0, mdl[2]}, 34'h0);
    mdl[3] = 7'h2c;
    xfer(1'b0, 8'h70, 4'h1, {25'h0, mdl[3]}, 34'h0);
    mdl[0] = 7'h53;
    xfer(1'b0, 8'h64, 4'h1, {25'h0, mdl[0]}, 34'h0);
    rdAll();
    @(posedge clk);
    test_done();
  end
endmodule : pll_enable_and_loop_filter_regs_tb_top
`default_nettype wire
